// ==== rtl/ksd_kernel_decoder.v ====
// kernel-mode virtual address segment decoder, registered outputs
// assumes fetch/load-store logic on mclk_in drives inputs, tlb consumes
// Notes on behaviour
// - narrow addresses copy bit 31 upward first
// - kernel when mode 00, exception or error
// - wide flag picks 32- or 64-bit map
// - narrow bit31 clear: 2 GB tlb user region
// - mapped regions carry 8-bit space identifier
// - mapped cacheability from tlb page attribute
// - error flag: narrow user region and wide low 2 GB unmapped, uncached
// - narrow 100: direct, subtract 0x8000_0000
// - direct cached regions use config attribute
// - narrow 101: direct uncached, subtract 0xA000_0000
// - narrow 110: 512 MB tlb super region
// - narrow 111: 512 MB tlb top region
// - wide 00: 1 TB tlb user region
// - wide 01: 1 TB tlb super region
// - wide 10: untranslated physical window
// - physical window bits 58:32 set: error
// - window code 2 uncached, 0/1 cached
// - window codes 3 to 7 cached
// - wide 11 up to limit: tlb mapped
// - compat direct regions map to low 512 MB
// - compat uncached region bypasses caches
// - compat super and top go through tlb
`timescale 1ns/1ps
`default_nettype none
`include "ksd_defines.vh"
module ksd_kernel_decoder (
    input wire mclk_in, // core clock
    input wire sys_rst_in, // async reset, high
    input wire [63:0] vaddr_in, // virtual address
    input wire [1:0] privilege_mode_field_in, // privilege mode
    input wire exception_level_flag_in, // exception level
    input wire error_level_flag_in, // error level
    input wire kernel_wide_addressing_in, // 64-bit kernel map
    input wire [7:0] address_space_identifier_in, // current address_space_identifier
    input wire [2:0] kernel_low_window_attribute_in, // config attribute
    input wire [2:0] page_attribute_bits_in, // matching tlb entry attr
    output reg kernel_mode_out, // decoding in kernel mode
    output reg [3:0] region_out, // one-hot region class
    output reg tlb_req_out, // lookup through tlb
    output reg [71:0] tlb_vaddr_out, // address_space_identifier plus virtual address
    output reg [31:0] paddr_out, // direct physical address
    output reg cached_out, // access may use caches
    output reg addr_err_out // address error
);
    wire [63:0] va;
    wire cfg_cached;
    wire tlb_cached;
    wire win_cached;
    reg [3:0] nxt_region;
    reg nxt_tlb;
    reg [31:0] nxt_paddr;
    reg nxt_cached;
    reg nxt_err;
    reg nxt_kernel;
    wire compat_hit;
    wire phys_hole;
    wire narrow_user; // bit 31 clear in narrow map
    wire [2:0] seg_sel; // narrow segment select bits
    wire [1:0] quad_sel; // wide map quadrant bits
    wire [21:0] reach_bits; // clear inside 1 tb regions
    wire [2:0] win_code; // physical window cache code
    wire [1:0] cpt_sel; // compat window select bits
    wire [31:0] low_word; // low half of effective address
    wire low_upper_clear; // bits 63:31 all zero
    wire reach_ok; // inside a 1 tb region
    wire kseg_ok; // at or below the mapped kernel limit
    wire [71:0] nxt_tlb_vaddr; // address_space_identifier-extended lookup address

    // narrow addressing sign-extends before any decode
    ksd_sext u_sext (
        .vaddr_in(vaddr_in),
        .narrow_in(~kernel_wide_addressing_in),
        .vaddr_out(va)
    );

    // one attribute decoder per cacheability source
    ksd_cache_attr u_cfg_attr (
        .code_in(kernel_low_window_attribute_in),
        .cached_out(cfg_cached)
    );
    ksd_cache_attr u_tlb_attr (
        .code_in(page_attribute_bits_in),
        .cached_out(tlb_cached)
    );
    ksd_cache_attr u_win_attr (
        .code_in(win_code),
        .cached_out(win_cached)
    );

    // named address fields; after widening, the narrow map only
    // looks at the low word, so stray upper bits cannot steer it
    assign narrow_user = ~va[`KSD_SIGN_BIT];
    assign seg_sel = va[`KSD_NSEG_HI:`KSD_NSEG_LO];
    assign quad_sel = va[`KSD_WSEG_HI:`KSD_WSEG_LO];
    assign reach_bits = va[`KSD_REACH_HI:`KSD_REACH_LO];
    assign win_code = va[`KSD_WATTR_HI:`KSD_WATTR_LO];
    assign cpt_sel = va[`KSD_CPT_HI:`KSD_CPT_LO];
    assign low_word = va[`KSD_LOW_HI:`KSD_LOW_LO];

    // compat regions need bits 63:31 all ones
    assign compat_hit = &va[`KSD_WSEG_HI:`KSD_UPPER_LO];
    // error-level direct window is only the low 2 GB, not all 1 TB
    assign low_upper_clear = ~|va[`KSD_WSEG_HI:`KSD_UPPER_LO];
    // physical window only reaches 4 GB per code
    assign phys_hole = |va[`KSD_HOLE_HI:`KSD_HOLE_LO];
    // 1 tb regions need bits 61:40 clear; the rest is a hole
    assign reach_ok = (reach_bits == `KSD_REACH_CLEAR);
    // top quadrant is mapped only up to its fixed limit
    assign kseg_ok = (va <= `KSD_KSEG_LIMIT);

    // every mapped lookup carries the current space identifier
    assign nxt_tlb_vaddr = {address_space_identifier_in, va};

    // segment classification; error wins over mapping for the narrow user region and the wide low 2 GB
    always @*
    begin
        nxt_kernel = (privilege_mode_field_in == `KSD_PRIV_KERNEL)
            | exception_level_flag_in | error_level_flag_in;
        nxt_region = `KSD_REG_NONE;
        nxt_tlb = 1'b0;
        nxt_paddr = 32'h0000_0000;
        nxt_cached = 1'b0;
        nxt_err = 1'b0;
        if (!nxt_kernel)
        begin
            // user and supervisor decode live elsewhere
            nxt_region = `KSD_REG_NONE;
        end
        else if (!kernel_wide_addressing_in)
        begin
            if (narrow_user)
            begin
                if (error_level_flag_in)
                begin
                    // cache error handler runs here with no tlb
                    nxt_region = `KSD_REG_USER;
                    nxt_paddr = low_word;
                    nxt_cached = 1'b0;
                end
                else
                begin
                    nxt_region = `KSD_REG_MAPPED;
                    nxt_tlb = 1'b1;
                    nxt_cached = tlb_cached;
                end
            end
            else if (seg_sel == `KSD_SEG_DCACHED)
            begin
                nxt_region = `KSD_REG_DIRECT;
                nxt_paddr = low_word - `KSD_OFS_CACHED;
                nxt_cached = cfg_cached;
            end
            else if (seg_sel == `KSD_SEG_DUNCACHED)
            begin
                nxt_region = `KSD_REG_DIRECT;
                nxt_paddr = low_word - `KSD_OFS_UNCACHED;
                nxt_cached = 1'b0;
            end
            else if (seg_sel == `KSD_SEG_SUPER)
            begin
                nxt_region = `KSD_REG_MAPPED;
                nxt_tlb = 1'b1;
                nxt_cached = tlb_cached;
            end
            else
            begin
                // only the top segment is left
                nxt_region = `KSD_REG_MAPPED;
                nxt_tlb = 1'b1;
                nxt_cached = tlb_cached;
            end
        end
        else if (quad_sel == `KSD_WIN_USER)
        begin
            if (error_level_flag_in && low_upper_clear)
            begin
                nxt_region = `KSD_REG_USER;
                nxt_paddr = low_word;
                nxt_cached = 1'b0;
            end
            else if (reach_ok)
            begin
                nxt_region = `KSD_REG_MAPPED;
                nxt_tlb = 1'b1;
                nxt_cached = tlb_cached;
            end
            else
            begin
                nxt_err = 1'b1;
            end
        end
        else if (quad_sel == `KSD_WIN_SUPER)
        begin
            if (reach_ok)
            begin
                nxt_region = `KSD_REG_MAPPED;
                nxt_tlb = 1'b1;
                nxt_cached = tlb_cached;
            end
            else
            begin
                nxt_err = 1'b1;
            end
        end
        else if (quad_sel == `KSD_WIN_PHYS)
        begin
            // a hole address must never reach memory, so error wins
            if (phys_hole)
            begin
                nxt_err = 1'b1;
            end
            else
            begin
                nxt_region = `KSD_REG_DIRECT;
                nxt_paddr = low_word;
                nxt_cached = win_cached;
            end
        end
        else if (kseg_ok)
        begin
            // quadrant 11 at or below the limit: plain mapped kernel space
            nxt_region = `KSD_REG_MAPPED;
            nxt_tlb = 1'b1;
            nxt_cached = tlb_cached;
        end
        else if (compat_hit)
        begin
            if (cpt_sel == `KSD_CPT_CACHED)
            begin
                nxt_region = `KSD_REG_DIRECT;
                nxt_paddr = low_word - `KSD_OFS_CACHED;
                nxt_cached = cfg_cached;
            end
            else if (cpt_sel == `KSD_CPT_UNCACHED)
            begin
                nxt_region = `KSD_REG_DIRECT;
                nxt_paddr = low_word - `KSD_OFS_UNCACHED;
                nxt_cached = 1'b0;
            end
            else if (cpt_sel == `KSD_CPT_SUPER)
            begin
                nxt_region = `KSD_REG_MAPPED;
                nxt_tlb = 1'b1;
                nxt_cached = tlb_cached;
            end
            else
            begin
                // compat top segment, mapped like the narrow one
                nxt_region = `KSD_REG_MAPPED;
                nxt_tlb = 1'b1;
                nxt_cached = tlb_cached;
            end
        end
        else
        begin
            // gap between mapped kernel region and compat window
            nxt_err = 1'b1;
        end
    end

    // one register stage so every output comes from a flop;
    // the tlb attribute must arrive in the same cycle as its address
    always @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            kernel_mode_out <= 1'b0;
            region_out <= `KSD_REG_NONE;
            tlb_req_out <= 1'b0;
            paddr_out <= 32'h0000_0000;
            cached_out <= 1'b0;
            addr_err_out <= 1'b0;
        end
        else
        begin
            kernel_mode_out <= nxt_kernel;
            region_out <= nxt_region;
            tlb_req_out <= nxt_tlb;
            paddr_out <= nxt_paddr;
            cached_out <= nxt_cached;
            addr_err_out <= nxt_err;
        end
    end

    // the wide lookup address loads every cycle, mapped or not, so the
    // tlb can start its compare before the region class is known
    always @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            tlb_vaddr_out <= 72'h00_0000_0000_0000_0000;
        end
        else
        begin
            tlb_vaddr_out <= nxt_tlb_vaddr;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/ksd_defines.vh ====
// constants for the kernel segment decoder
// assumes inclusion by bare name from design files under rtl/
`ifndef KSD_DEFINES_VH
`define KSD_DEFINES_VH
`define KSD_PRIV_KERNEL 2'h0
`define KSD_SEG_USER 3'h0
`define KSD_SEG_DCACHED 3'h4
`define KSD_SEG_DUNCACHED 3'h5
`define KSD_SEG_SUPER 3'h6
`define KSD_SEG_TOP 3'h7
`define KSD_WIN_USER 2'h0
`define KSD_WIN_SUPER 2'h1
`define KSD_WIN_PHYS 2'h2
`define KSD_WIN_KSEG 2'h3
`define KSD_ATTR_UNCACHED 3'h2
`define KSD_CPT_CACHED 2'h0
`define KSD_CPT_UNCACHED 2'h1
`define KSD_CPT_SUPER 2'h2
`define KSD_REACH_CLEAR 22'h00_0000
// address field positions
`define KSD_SIGN_BIT 31
`define KSD_NSEG_HI 31
`define KSD_NSEG_LO 29
`define KSD_WSEG_HI 63
`define KSD_WSEG_LO 62
`define KSD_REACH_HI 61
`define KSD_REACH_LO 40
`define KSD_WATTR_HI 61
`define KSD_WATTR_LO 59
`define KSD_HOLE_HI 58
`define KSD_HOLE_LO 32
`define KSD_CPT_HI 30
`define KSD_CPT_LO 29
`define KSD_LOW_HI 31
`define KSD_LOW_LO 0
`define KSD_UPPER_LO 31
`define KSD_OFS_CACHED 32'h8000_0000
`define KSD_OFS_UNCACHED 32'hA000_0000
`define KSD_KSEG_LIMIT 64'hC000_00FF_7FFF_FFFF
`define KSD_COMPAT_BASE 64'hFFFF_FFFF_8000_0000
`define KSD_REG_NONE 4'h1
`define KSD_REG_USER 4'h2
`define KSD_REG_DIRECT 4'h4
`define KSD_REG_MAPPED 4'h8
`endif

// ==== rtl/ksd_cache_attr.v ====
// maps a three-bit cache algorithm code to cached or uncached
// assumes a code from a tlb entry, config field or address bits
`timescale 1ns/1ps
`default_nettype none
`include "ksd_defines.vh"
module ksd_cache_attr (
    input wire [2:0] code_in, // cache algorithm code
    output wire cached_out // high when cached
);
    // only code 2 is uncached; every other code caches
    assign cached_out = (code_in != `KSD_ATTR_UNCACHED);
endmodule
`default_nettype wire

// ==== rtl/ksd_sext.v ====
// widens a 32-bit address by copying bit 31 upward
// assumes a purely combinational use
`timescale 1ns/1ps
`default_nettype none
module ksd_sext (
    input wire [63:0] vaddr_in, // raw address
    input wire narrow_in, // 32-bit addressing
    output wire [63:0] vaddr_out // effective address
);
    // narrow mode ignores the raw upper half entirely
    assign vaddr_out = narrow_in ? {{32{vaddr_in[31]}}, vaddr_in[31:0]} : vaddr_in;
endmodule
`default_nettype wire

// ==== sim/ksd_addr_path.sv ====
// model of the fetch and load/store path feeding the decoder
// assumes the bench calls issue once per transfer
`timescale 1ns/1ps
`default_nettype none
module ksd_addr_path (
    input wire logic clk_in, // core clock
    output logic [63:0] vaddr_out, // virtual address
    output logic [1:0] mode_out, // privilege mode
    output logic exc_lvl_out, // exception level
    output logic err_lvl_out, // error level
    output logic wide_out, // wide kernel map
    output logic [7:0] address_space_identifier_out, // space identifier
    output logic [2:0] kattr_out, // config attribute
    output logic [2:0] pattr_out // tlb entry attribute
);
    // idle as a plain user-mode fetch
    initial
    begin
        {vaddr_out, mode_out, exc_lvl_out, err_lvl_out, wide_out} = {64'h0, 2'h2, 3'h0};
        {address_space_identifier_out, kattr_out, pattr_out} = 14'h0;
    end
    // address_space_identifier moves every transfer so a stale copy shows up
    task issue(input logic [63:0] v, input logic [4:0] c, input logic [2:0] ka, pa);
        @(posedge clk_in);
        #1;
        vaddr_out = v;
        {wide_out, mode_out, exc_lvl_out, err_lvl_out} = c;
        kattr_out = ka;
        pattr_out = pa;
        address_space_identifier_out = address_space_identifier_out + 8'h3B;
    endtask
endmodule
`default_nettype wire

// ==== sim/ksd_monitor.sv ====
// assertions on the kernel segment decoder ports
// assumes fixed one-cycle latency from inputs to outputs
`timescale 1ns/1ps
`default_nettype none
module ksd_monitor (
    input wire logic mclk_in, // core clock
    input wire logic sys_rst_in, // async reset
    input wire logic [63:0] vaddr_in, // address
    input wire logic [1:0] privilege_mode_field_in, // mode
    input wire logic exception_level_flag_in, // exception
    input wire logic error_level_flag_in, // error
    input wire logic kernel_wide_addressing_in, // wide map
    input wire logic [7:0] address_space_identifier_in, // address_space_identifier
    input wire logic [2:0] kernel_low_window_attribute_in, // config
    input wire logic [2:0] page_attribute_bits_in, // tlb attr
    input wire logic kernel_mode_out, // kernel
    input wire logic [3:0] region_out, // region
    input wire logic tlb_req_out, // tlb lookup
    input wire logic [71:0] tlb_vaddr_out, // tlb address
    input wire logic [31:0] paddr_out, // physical
    input wire logic cached_out, // cached
    input wire logic addr_err_out // error
);
    logic live_ff;
    wire kern = privilege_mode_field_in == 2'h0 || exception_level_flag_in || error_level_flag_in;
    wire narrow = kern && !kernel_wide_addressing_in;
    wire [2:0] top3 = vaddr_in[31:29];
    // first edge after reset still shows reset values, so skip it
    always @(posedge mclk_in or posedge sys_rst_in)
    begin
        live_ff <= !sys_rst_in;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in || !live_ff);
    a_mode_tracks: assert property (kernel_mode_out == $past(kern))
        else $error("kernel mode flag wrong");
    a_idle_user: assert property ($past(!kern) |-> region_out == 4'h1 && !tlb_req_out)
        else $error("non-kernel access not idle");
    a_direct_cached: assert property ($past(narrow && top3 == 3'h4) |-> !tlb_req_out
        && paddr_out == $past(vaddr_in[31:0]) - 32'h8000_0000
        && cached_out == ($past(kernel_low_window_attribute_in) != 3'h2))
        else $error("direct cached window wrong");
    a_direct_uncached: assert property ($past(narrow && top3 == 3'h5) |-> !cached_out
        && paddr_out == $past(vaddr_in[31:0]) - 32'hA000_0000)
        else $error("direct uncached window wrong");
    a_narrow_tlb: assert property ($past(narrow && top3 >= 3'h6) |-> tlb_req_out)
        else $error("narrow mapped window not sent to tlb");
    a_address_space_identifier_extend: assert property (tlb_req_out |->
        tlb_vaddr_out[71:64] == $past(address_space_identifier_in))
        else $error("tlb address lacks address_space_identifier");
    a_tlb_attr: assert property (tlb_req_out |->
        cached_out == ($past(page_attribute_bits_in) != 3'h2))
        else $error("mapped cacheability wrong");
    a_phys_error: assert property ($past(kern && kernel_wide_addressing_in
        && vaddr_in[63:62] == 2'h2 && |vaddr_in[58:32]) |-> addr_err_out)
        else $error("physical window error missed");
    a_sign_extend: assert property ($past(narrow) |->
        tlb_vaddr_out[63:0] == {{32{$past(vaddr_in[31])}}, $past(vaddr_in[31:0])})
        else $error("narrow address not widened");
    c_tlb: cover property (tlb_req_out);
    c_err: cover property (addr_err_out);
    c_user_direct: cover property (region_out == 4'h2);
endmodule
bind ksd_kernel_decoder ksd_monitor ksd_monitor_i (.*);
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the kernel segment decoder
// assumes decoder outputs settle one cycle after inputs
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [2:0] ka = 3'h3;
    logic [2:0] pa = 3'h0;
    int failures = 0;
    int check_count = 0;
    wire [63:0] va;
    wire [1:0] md;
    wire exc_lvl, err_lvl, wide, kmode, treq, aerr, cch;
    wire [7:0] address_space_identifier;
    wire [2:0] kat, pat;
    wire [3:0] reg4;
    wire [71:0] tva;
    wire [31:0] pad;
    always #2.5 mclk_in = ~mclk_in;
    ksd_addr_path ksd_addr_path_i (.clk_in(mclk_in), .vaddr_out(va), .mode_out(md),
        .exc_lvl_out(exc_lvl), .err_lvl_out(err_lvl), .wide_out(wide),
        .address_space_identifier_out(address_space_identifier), .kattr_out(kat), .pattr_out(pat));
    ksd_kernel_decoder ksd_kernel_decoder_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .vaddr_in(va), .privilege_mode_field_in(md), .exception_level_flag_in(exc_lvl),
        .error_level_flag_in(err_lvl), .kernel_wide_addressing_in(wide),
        .address_space_identifier_in(address_space_identifier), .kernel_low_window_attribute_in(kat),
        .page_attribute_bits_in(pat), .kernel_mode_out(kmode), .region_out(reg4),
        .tlb_req_out(treq), .tlb_vaddr_out(tva), .paddr_out(pad), .cached_out(cch),
        .addr_err_out(aerr));
    task chk(input string nm, input logic [71:0] e, g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // reset holds every output at its idle value
    task chk_idle;
        chk("reset region", 4'h1, reg4);
        chk("reset kernel", 1'b0, kmode);
        chk("reset tlb", 1'b0, treq);
        chk("reset error", 1'b0, aerr);
        chk("reset paddr", 32'h0000_0000, pad);
        chk("reset cached", 1'b0, cch);
        chk("reset tlbaddr", 72'h00_0000_0000_0000_0000, tva);
    endtask
    // r of zero means an address error is expected
    task go(input logic [63:0] v, input logic [4:0] c, input logic [3:0] r,
            input logic [31:0] p, input logic ch);
        logic [63:0] eff;
        eff = c[4] ? v : {{32{v[31]}}, v[31:0]};
        ksd_addr_path_i.issue(v, c, ka, pa);
        @(posedge mclk_in);
        #1;
        chk("region", (r == 4'h0) ? 4'h1 : r, reg4);
        chk("error", r == 4'h0, aerr);
        chk("kernel", r != 4'h1, kmode);
        chk("paddr", p, pad);
        chk("tlb", r == 4'h8, treq);
        if (r == 4'h8) chk("tlbaddr", {address_space_identifier, eff}, tva);
        if (r[3:1] != 3'h0) chk("cached", ch, cch);
    endtask
    task t_narrow;
        go(64'h1234_5678_8000_0004, 5'h00, 4'h4, 32'h4, 1'b1);
        ka = 3'h2;
        go(64'h0000_0000_8000_0004, 5'h00, 4'h4, 32'h4, 1'b0);
        go(64'h0000_0000_A000_0010, 5'h00, 4'h4, 32'h10, 1'b0);
        go(64'h0000_0000_0000_1000, 5'h00, 4'h8, 32'h0, 1'b1);
        pa = 3'h2;
        go(64'h0000_0000_C000_0000, 5'h00, 4'h8, 32'h0, 1'b0);
        go(64'hFFFF_FFFF_E000_0000, 5'h00, 4'h8, 32'h0, 1'b0);
        go(64'h0000_0000_7FFF_FFFF, 5'h01, 4'h2, 32'h7FFF_FFFF, 1'b0);
    endtask
    // reset in mid-run; the first edge after release decodes what stands
    task t_reset;
        go(64'h0000_0000_9000_0020, 5'h00, 4'h4, 32'h1000_0020, 1'b0);
        sys_rst_in = 1'b1;
        @(posedge mclk_in);
        #1;
        chk_idle;
        sys_rst_in = 1'b0;
        @(posedge mclk_in);
        #1;
        chk("region after reset", 4'h4, reg4);
        chk("paddr after reset", 32'h1000_0020, pad);
    endtask
    task t_mode;
        go(64'h0000_0000_8000_0004, 5'h08, 4'h1, 32'h0, 1'b0);
        go(64'h0000_0000_8000_0004, 5'h04, 4'h1, 32'h0, 1'b0);
        go(64'h0000_0000_8000_0004, 5'h0A, 4'h4, 32'h4, 1'b0);
        go(64'h0000_0000_8000_0004, 5'h09, 4'h4, 32'h4, 1'b0);
    endtask
    task t_wide;
        pa = 3'h3;
        ka = 3'h3;
        go(64'h0000_00FF_FFFF_FFFF, 5'h10, 4'h8, 32'h0, 1'b1);
        go(64'h0000_0100_0000_0000, 5'h10, 4'h0, 32'h0, 1'b0);
        go(64'h4000_00FF_0000_0000, 5'h10, 4'h8, 32'h0, 1'b1);
        for (int k = 0; k < 8; k++)
            go({2'h2, k[2:0], 27'h0, 32'h1234_5678}, 5'h10, 4'h4, 32'h1234_5678, k != 2);
        go(64'h8000_0001_0000_0000, 5'h10, 4'h0, 32'h0, 1'b0);
        go(64'hC000_00FF_7FFF_FFFF, 5'h10, 4'h8, 32'h0, 1'b1);
        go(64'hC000_00FF_8000_0000, 5'h10, 4'h0, 32'h0, 1'b0);
        go(64'hFFFF_FFFF_8000_0010, 5'h10, 4'h4, 32'h10, 1'b1);
        go(64'hFFFF_FFFF_A000_0010, 5'h10, 4'h4, 32'h10, 1'b0);
        go(64'hFFFF_FFFF_C000_0000, 5'h10, 4'h8, 32'h0, 1'b1);
        go(64'hFFFF_FFFF_E000_0000, 5'h10, 4'h8, 32'h0, 1'b1);
        go(64'h0000_0000_0000_0040, 5'h11, 4'h2, 32'h40, 1'b0);
    endtask
    task summarize;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // whole run is about 70 cycles; the limit leaves ample margin
    initial
    begin
        #5000;
        failures++;
        summarize;
    end
    initial
    begin
        repeat (5) @(posedge mclk_in);
        #1;
        chk_idle;
        sys_rst_in = 1'b0;
        t_narrow;
        t_reset;
        t_mode;
        t_wide;
        summarize;
    end
endmodule
`default_nettype wire
